/* File: verilog/tpc_pkg.sv */
//------------------------------------------------------------------------------
// Operation
// - both counters share one divider, each with its own clock select
// - select one gives a count pulse on every system clock cycle
// - divider taps at clock over 8, 64, 256 and 1024, all selectable
// - divider runs free, untouched by any counter's clock select
// - first tap pulse after enabling comes 1 to N cycles later
// - each count pin is sampled every cycle through synchronising stages
// - select seven counts rising pin edges, select six falling ones
// - pin edge to counter update takes 2 to 3 cycles
// - pin-derived count pulses never pass through the divider
// - hold mode bit set keeps the written divider reset bit asserted
// - hold mode bit written zero makes hardware clear divider reset
// - divider reset bit resets divider, then self-clears unless holding
// - divider reset lets software align first prescaled count to code
// - select zero gives no count pulses, counter stays stopped
// - pin transitions count even when the pin is driven as output
//------------------------------------------------------------------------------
package tpc_pkg;

  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned NUM_CNT = 2;
  localparam int unsigned SEL_W   = 3;
  localparam int unsigned DIV_W   = 10;

  // register byte offsets
  localparam logic [ADDR_W-1:0] SYNC_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] SEL0_OFS      = 8'h04;
  localparam logic [ADDR_W-1:0] SEL1_OFS      = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h0C;

  // general_timer_sync_control fields
  localparam int unsigned TSM_BIT = 7;
  localparam int unsigned PSR_BIT = 0;

  // status fields
  localparam int unsigned STAT_DIV_LSB = 0;
  localparam int unsigned STAT_PIN_LSB = 16;

  // reset values
  localparam logic             SYNC_HOLD_RST = 1'b0;
  localparam logic             PSR_RST       = 1'b0;
  localparam logic [SEL_W-1:0] SEL_RST       = 3'h0;
  localparam logic [DIV_W-1:0] DIV_RST       = 10'h000;

  // clock_select_field encodings
  localparam logic [SEL_W-1:0] CS_STOP     = 3'h0;
  localparam logic [SEL_W-1:0] CS_DIV1     = 3'h1;
  localparam logic [SEL_W-1:0] CS_DIV8     = 3'h2;
  localparam logic [SEL_W-1:0] CS_DIV64    = 3'h3;
  localparam logic [SEL_W-1:0] CS_DIV256   = 3'h4;
  localparam logic [SEL_W-1:0] CS_DIV1024  = 3'h5;
  localparam logic [SEL_W-1:0] CS_EXT_FALL = 3'h6;
  localparam logic [SEL_W-1:0] CS_EXT_RISE = 3'h7;

  // a tap fires when the masked divider bits are all ones
  localparam logic [DIV_W-1:0] TAP8_MASK    = 10'h007;
  localparam logic [DIV_W-1:0] TAP64_MASK   = 10'h03F;
  localparam logic [DIV_W-1:0] TAP256_MASK  = 10'h0FF;
  localparam logic [DIV_W-1:0] TAP1024_MASK = 10'h3FF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    TPC_REG_SYNC,
    TPC_REG_SEL0,
    TPC_REG_SEL1,
    TPC_REG_STATUS,
    TPC_REG_NONE
  } tpc_reg_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   awaddr;
    logic                awvalid;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W/8-1:0] wstrb;
    logic                wvalid;
    logic                bready;
    logic [ADDR_W-1:0]   araddr;
    logic                arvalid;
    logic                rready;
  } tpc_axi_req_t;

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic [1:0]          bresp;
    logic                bvalid;
    logic                arready;
    logic [DATA_W-1:0]   rdata;
    logic [1:0]          rresp;
    logic                rvalid;
  } tpc_axi_rsp_t;

endpackage

/* File: verilog/tpc_top.sv */
// The register offsets and the AXI4-Lite register port were left to the implementer.
module tpc_top (
  input  wire logic                      clk_in,     // i/o system clock
  input  wire logic                      rst_n_in,   // async reset, low
  input  wire logic                      clk_en_in,  // freezes all state
  input  wire tpc_pkg::tpc_axi_req_t     axi_in,     // axi4-lite request
  output tpc_pkg::tpc_axi_rsp_t          axi_out,    // axi4-lite response
  input  wire logic [tpc_pkg::NUM_CNT-1:0] ext_pin_in, // external count pins
  output logic [tpc_pkg::NUM_CNT-1:0]    count_tick_out, // count strobes
  output logic                           prescaler_reset_out // divider held
);
  import tpc_pkg::*;

  function automatic tpc_reg_t reg_decode(input logic [ADDR_W-1:0] addr);
    if (addr == SYNC_CTRL_OFS) begin
      reg_decode = TPC_REG_SYNC;
    end else if (addr == SEL0_OFS) begin
      reg_decode = TPC_REG_SEL0;
    end else if (addr == SEL1_OFS) begin
      reg_decode = TPC_REG_SEL1;
    end else if (addr == STATUS_OFS) begin
      reg_decode = TPC_REG_STATUS;
    end else begin
      reg_decode = TPC_REG_NONE;
    end
  endfunction

  //----------------------------------------------------------------------------
  // register bus
  //----------------------------------------------------------------------------
  logic                          aw_seen_q, aw_seen_d;
  logic                          w_seen_q, w_seen_d;
  logic [ADDR_W-1:0]             awaddr_q, awaddr_d;
  logic [DATA_W-1:0]             wdata_q, wdata_d;
  logic [DATA_W/8-1:0]           wstrb_q, wstrb_d;
  logic                          bvalid_q, bvalid_d;
  logic [1:0]                    bresp_q, bresp_d;
  logic                          rvalid_q, rvalid_d;
  logic [1:0]                    rresp_q, rresp_d;
  logic [DATA_W-1:0]             rdata_q, rdata_d;
  logic                          sync_hold_q, sync_hold_d;
  logic                          psr_q, psr_d;
  logic [NUM_CNT-1:0][SEL_W-1:0] sel_q, sel_d;
  logic                          wr_fire;
  tpc_reg_t                      wr_reg;
  tpc_reg_t                      rd_reg;
  logic                          aw_take, w_take, ar_take;

  // divider and synchroniser state, declared here for the status read
  logic [DIV_W-1:0]              div_q, div_d;
  logic [NUM_CNT-1:0]            sync1_q, sync1_d;
  logic [NUM_CNT-1:0]            sync2_q, sync2_d;
  logic [NUM_CNT-1:0]            prev_q, prev_d;

  assign aw_take = clk_en_in && axi_in.awvalid && !aw_seen_q;
  assign w_take  = clk_en_in && axi_in.wvalid && !w_seen_q;
  assign ar_take = clk_en_in && axi_in.arvalid && !rvalid_q;
  assign wr_fire = clk_en_in && aw_seen_q && w_seen_q && !bvalid_q;
  assign wr_reg  = reg_decode(awaddr_q);
  assign rd_reg  = reg_decode(axi_in.araddr);

  always_comb begin
    aw_seen_d   = aw_seen_q;
    w_seen_d    = w_seen_q;
    awaddr_d    = awaddr_q;
    wdata_d     = wdata_q;
    wstrb_d     = wstrb_q;
    bvalid_d    = bvalid_q;
    bresp_d     = bresp_q;
    rvalid_d    = rvalid_q;
    rresp_d     = rresp_q;
    rdata_d     = rdata_q;
    sync_hold_d = sync_hold_q;
    sel_d       = sel_q;
    // without a write the strobe self-clears unless hold mode keeps it
    psr_d       = sync_hold_q ? psr_q : 1'b0;
    if (aw_take) begin
      aw_seen_d = 1'b1;
      awaddr_d  = axi_in.awaddr;
    end
    if (w_take) begin
      w_seen_d = 1'b1;
      wdata_d  = axi_in.wdata;
      wstrb_d  = axi_in.wstrb;
    end
    if (wr_fire) begin
      aw_seen_d = 1'b0;
      w_seen_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      if (wr_reg == TPC_REG_SYNC) begin
        if (wstrb_q[0]) begin
          // software write wins over the hardware clear
          sync_hold_d = wdata_q[TSM_BIT];
          psr_d       = wdata_q[PSR_BIT];
        end
      end else if (wr_reg == TPC_REG_SEL0) begin
        if (wstrb_q[0]) begin
          sel_d[0] = wdata_q[SEL_W-1:0];
        end
      end else if (wr_reg == TPC_REG_SEL1) begin
        if (wstrb_q[0]) begin
          sel_d[1] = wdata_q[SEL_W-1:0];
        end
      end else if (wr_reg == TPC_REG_STATUS) begin
        bresp_d = RESP_OKAY;
      end else begin
        bresp_d = RESP_SLVERR;
      end
    end
    if (clk_en_in && bvalid_q && axi_in.bready) begin
      bvalid_d = 1'b0;
    end
    if (clk_en_in && rvalid_q && axi_in.rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      if (rd_reg == TPC_REG_SYNC) begin
        rdata_d[TSM_BIT] = sync_hold_q;
        rdata_d[PSR_BIT] = psr_q;
      end else if (rd_reg == TPC_REG_SEL0) begin
        rdata_d[SEL_W-1:0] = sel_q[0];
      end else if (rd_reg == TPC_REG_SEL1) begin
        rdata_d[SEL_W-1:0] = sel_q[1];
      end else if (rd_reg == TPC_REG_STATUS) begin
        rdata_d[STAT_DIV_LSB +: DIV_W]  = div_q;
        rdata_d[STAT_PIN_LSB +: NUM_CNT] = sync2_q;
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_seen_q   <= 1'b0;
      w_seen_q    <= 1'b0;
      awaddr_q    <= '0;
      wdata_q     <= '0;
      wstrb_q     <= '0;
      bvalid_q    <= 1'b0;
      bresp_q     <= RESP_OKAY;
      rvalid_q    <= 1'b0;
      rresp_q     <= RESP_OKAY;
      rdata_q     <= '0;
      sync_hold_q <= SYNC_HOLD_RST;
      psr_q       <= PSR_RST;
      sel_q       <= {NUM_CNT{SEL_RST}};
    end else if (clk_en_in) begin
      aw_seen_q   <= aw_seen_d;
      w_seen_q    <= w_seen_d;
      awaddr_q    <= awaddr_d;
      wdata_q     <= wdata_d;
      wstrb_q     <= wstrb_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rresp_q     <= rresp_d;
      rdata_q     <= rdata_d;
      sync_hold_q <= sync_hold_d;
      psr_q       <= psr_d;
      sel_q       <= sel_d;
    end
  end

  always_comb begin
    axi_out         = '0;
    axi_out.awready = clk_en_in && !aw_seen_q;
    axi_out.wready  = clk_en_in && !w_seen_q;
    axi_out.bvalid  = bvalid_q;
    axi_out.bresp   = bresp_q;
    axi_out.arready = clk_en_in && !rvalid_q;
    axi_out.rvalid  = rvalid_q;
    axi_out.rresp   = rresp_q;
    axi_out.rdata   = rdata_q;
  end

  //----------------------------------------------------------------------------
  // shared divider
  //----------------------------------------------------------------------------
  logic [3:0] tap;

  // free running: no clock select feeds this, only the reset strobe
  always_comb begin
    div_d = psr_q ? DIV_RST : div_q + 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q <= DIV_RST;
    end else if (clk_en_in) begin
      div_q <= div_d;
    end
  end

  // counting from zero, a tap needs a full period before it fires,
  // so enabling mid-phase waits anywhere from 1 to N cycles
  assign tap[0] = !psr_q && ((div_q & TAP8_MASK) == TAP8_MASK);
  assign tap[1] = !psr_q && ((div_q & TAP64_MASK) == TAP64_MASK);
  assign tap[2] = !psr_q && ((div_q & TAP256_MASK) == TAP256_MASK);
  assign tap[3] = !psr_q && ((div_q & TAP1024_MASK) == TAP1024_MASK);
  assign prescaler_reset_out = psr_q;

  //----------------------------------------------------------------------------
  // pin synchronisers and edge detectors
  //----------------------------------------------------------------------------
  // pins are sampled whatever their port direction, so software can
  // drive them to count
  always_comb begin
    sync1_d = ext_pin_in;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else if (clk_en_in) begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
    end
  end

  pin_sync_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in
    |=> (sync1_q == $past(ext_pin_in) && sync2_q == $past(sync1_q)))
    else $error("count pins not sampled every cycle");

  //----------------------------------------------------------------------------
  // per-counter clock select
  //----------------------------------------------------------------------------
  // edge detectors always run, so a change of select on a steady pin
  // never makes a stray pulse; the strobe is combinational to keep
  // pin-to-update latency at three cycles at most
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      logic rise;
      logic fall;
      assign rise = sync2_q[gi] && !prev_q[gi];
      assign fall = !sync2_q[gi] && prev_q[gi];
      always_comb begin
        count_tick_out[gi] = 1'b0;
        case (sel_q[gi])
          CS_STOP:     count_tick_out[gi] = 1'b0;
          CS_DIV1:     count_tick_out[gi] = clk_en_in;
          CS_DIV8:     count_tick_out[gi] = clk_en_in && tap[0];
          CS_DIV64:    count_tick_out[gi] = clk_en_in && tap[1];
          CS_DIV256:   count_tick_out[gi] = clk_en_in && tap[2];
          CS_DIV1024:  count_tick_out[gi] = clk_en_in && tap[3];
          // pin modes take no tap at all
          CS_EXT_FALL: count_tick_out[gi] = clk_en_in && fall;
          CS_EXT_RISE: count_tick_out[gi] = clk_en_in && rise;
          default:     count_tick_out[gi] = 1'b0;
        endcase
      end

      sel_none_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        sel_q[gi] == CS_STOP |-> !count_tick_out[gi])
        else $error("tick while clock select is stop");

      sel_full_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (sel_q[gi] == CS_DIV1 && clk_en_in) |-> count_tick_out[gi])
        else $error("undivided select missed a cycle");

      ext_rise_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (sel_q[gi] == CS_EXT_RISE && clk_en_in && $past(clk_en_in)
         && count_tick_out[gi])
        |-> (!$past(sync2_q[gi]) && sync2_q[gi]))
        else $error("rising-edge tick without a rising pin");

      ext_fall_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (sel_q[gi] == CS_EXT_FALL && clk_en_in && $past(clk_en_in)
         && count_tick_out[gi])
        |-> ($past(sync2_q[gi]) && !sync2_q[gi]))
        else $error("falling-edge tick without a falling pin");

      ext_latency_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (clk_en_in [*3] ##0 sel_q[gi] == CS_EXT_RISE
         ##0 $rose(sync1_q[gi]))
        ##1 (clk_en_in && sel_q[gi] == CS_EXT_RISE)
        |-> count_tick_out[gi])
        else $error("pin edge strobe not within latency");

      tick_gap_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (sel_q[gi] == CS_DIV8 && count_tick_out[gi])
        |=> (sel_q[gi] != CS_DIV8 || !count_tick_out[gi]) [*7])
        else $error("divide-by-8 ticks closer than eight cycles");

      ext_once_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (sel_q[gi] == CS_EXT_RISE && count_tick_out[gi])
        |=> !(sel_q[gi] == CS_EXT_RISE && count_tick_out[gi]))
        else $error("one rising pin edge gave two ticks");
    end
  endgenerate

  //----------------------------------------------------------------------------
  // checks on divider and reset strobe
  //----------------------------------------------------------------------------
  div_run_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && !psr_q) |=> div_q == $past(div_q) + 1'b1)
    else $error("divider did not advance");

  div_zero_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && psr_q) |=> (div_q == DIV_RST && !tap[0]))
    else $error("divider not zeroed by reset strobe");

  tap_rst_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $fell(psr_q) |-> (!tap[0]) [*7])
    else $error("divide-by-8 tap fired early after divider reset");

  tap_nest_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (tap[3] |-> tap[2]) and (tap[2] |-> tap[1]) and (tap[1] |-> tap[0]))
    else $error("tap phases not nested");

  psr_clear_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && psr_q && !sync_hold_q && !wr_fire) |=> !psr_q)
    else $error("reset strobe did not self-clear");

  psr_hold_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && psr_q && sync_hold_q && !wr_fire) |=> psr_q)
    else $error("reset strobe lost in hold mode");

  tsm_release_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_fire && wr_reg == TPC_REG_SYNC && wstrb_q[0]
     && !wdata_q[TSM_BIT])
    ##1 (clk_en_in && !wr_fire) |=> !psr_q)
    else $error("hold release did not clear reset strobe");

endmodule

/* File: bench/tpc_far_end.sv */
module tpc_far_end #(
  parameter int unsigned HALF = 3
) (
  input  wire logic        clk_in,    // system clock
  input  wire logic        rst_n_in,  // async reset, low
  input  wire logic [1:0]  tick_in,   // count strobes from the block
  input  wire logic        run_in,    // let the pin clock run
  output logic      [1:0]  pin_out,   // both external count pins
  output logic      [31:0] cnt0_out,  // counter0 core value
  output logic      [31:0] cnt1_out,  // counter1 core value
  output logic      [31:0] rise_out   // rising pin edges driven
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       pin_q;
  logic [7:0] ph_q;

  assign pin_out = {pin_q, pin_q};

  //----------------------------------------------------------------------
  // counter cores and pin clock source
  //----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q    <= 1'b0;
      ph_q     <= 8'h00;
      cnt0_out <= 32'h0000_0000;
      cnt1_out <= 32'h0000_0000;
      rise_out <= 32'h0000_0000;
    end else begin
      if (tick_in[0]) begin
        cnt0_out <= cnt0_out + 32'h1;
      end
      if (tick_in[1]) begin
        cnt1_out <= cnt1_out + 32'h1;
      end
      // pin stands still when idle, ends every burst low
      if (run_in || pin_q) begin
        if (ph_q == 8'(HALF - 1)) begin // each phase several cycles
          ph_q  <= 8'h00;
          pin_q <= ~pin_q;
          if (!pin_q) begin
            rise_out <= rise_out + 32'h1;
          end
        end else begin
          ph_q <= ph_q + 8'h01;
        end
      end
    end
  end
endmodule

/* File: bench/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tpc_pkg::*;

  localparam logic [SEL_W-1:0] TAP_SEL [4] =
    '{CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
  localparam logic [31:0] TAP_DIV [4] = '{32'h8, 32'h40, 32'h100, 32'h400};

  logic         clk;
  logic         rst_n;
  logic         clk_en;
  logic         run;
  tpc_axi_req_t req;
  tpc_axi_rsp_t rsp;
  logic [1:0]   pins;
  logic [1:0]   ticks;
  logic         psr;
  logic [31:0]  cnt0;
  logic [31:0]  cnt1;
  logic [31:0]  rise;
  logic [31:0]  d0;
  logic [31:0]  d1;
  logic [31:0]  dr;
  int           n_mismatch = 0;
  int           cmp_count  = 0;

  tpc_top tpc_top_inst (
    .clk_in              (clk),
    .rst_n_in            (rst_n),
    .clk_en_in           (clk_en),
    .axi_in              (req),
    .axi_out             (rsp),
    .ext_pin_in          (pins),
    .count_tick_out      (ticks),
    .prescaler_reset_out (psr)
  );

  tpc_far_end tpc_far_end_inst (
    .clk_in   (clk),
    .rst_n_in (rst_n),
    .tick_in  (ticks),
    .run_in   (run),
    .pin_out  (pins),
    .cnt0_out (cnt0),
    .cnt1_out (cnt1),
    .rise_out (rise)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  //----------------------------------------------------------------------
  // reporting
  //----------------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    n_mismatch++;
    close_out();
  endtask

  //----------------------------------------------------------------------
  // axi4-lite master; handshakes judged at the falling edge before
  //----------------------------------------------------------------------
  task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int   n;
    logic aw;
    logic w;
    logic b;
    logic [1:0] r;
    @(posedge clk);
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b) begin
      @(negedge clk);
      aw = (req.awvalid & rsp.awready) === 1'b1;
      w  = (req.wvalid & rsp.wready) === 1'b1;
      b  = (req.bready & rsp.bvalid) === 1'b1;
      r  = rsp.bresp;
      @(posedge clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
      n++;
      if (n > 200) give_up();
    end
    chk(32'(r), 32'(er));
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int   n;
    logic ar;
    logic rv;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    rv = 1'b0;
    n  = 0;
    while (!rv) begin
      @(negedge clk);
      ar = (req.arvalid & rsp.arready) === 1'b1;
      rv = (req.rready & rsp.rvalid) === 1'b1;
      d  = rsp.rdata;
      r  = rsp.rresp;
      @(posedge clk);
      if (ar) req.arvalid <= 1'b0;
      if (rv) req.rready <= 1'b0;
      n++;
      if (n > 200) give_up();
    end
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask

  // ticks of both counters over n whole cycles
  task automatic meas(input int n, output logic [31:0] a,
                      output logic [31:0] b);
    logic [31:0] s0;
    logic [31:0] s1;
    @(negedge clk);
    s0 = cnt0;
    s1 = cnt1;
    repeat (n) @(negedge clk);
    a = cnt0 - s0;
    b = cnt1 - s1;
  endtask

  task automatic ext_run(input int n, output logic [31:0] a,
                         output logic [31:0] b, output logic [31:0] e);
    logic [31:0] s0;
    logic [31:0] s1;
    logic [31:0] sr;
    @(negedge clk);
    s0 = cnt0;
    s1 = cnt1;
    sr = rise;
    @(posedge clk);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
    // room for the last phase plus the synchroniser
    repeat (20) @(negedge clk);
    a = cnt0 - s0;
    b = cnt1 - s1;
    e = rise - sr;
  endtask

  //----------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------
  initial begin
    req    = '0;
    run    = 1'b0;
    clk_en = 1'b1;
    rst_n  = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(SYNC_CTRL_OFS, 32'h0, RESP_OKAY);
    rd_chk(SEL0_OFS, 32'h0, RESP_OKAY);
    rd_chk(SEL1_OFS, 32'h0, RESP_OKAY);
    rd_chk(8'h10, 32'h0, RESP_SLVERR);
    wr_chk(8'h10, 32'h5, RESP_SLVERR);
    wr_chk(STATUS_OFS, 32'h0, RESP_OKAY);
    meas(100, d0, d1);
    chk(d0, 32'h0);
    chk(d1, 32'h0);
    wr_chk(SEL0_OFS, 32'(CS_DIV1), RESP_OKAY);
    wr_chk(SEL1_OFS, 32'(CS_DIV8), RESP_OKAY);
    meas(200, d0, d1);
    chk(d0, 32'hC8);
    chk(d1, 32'h19);
    // a low clock enable must silence every count strobe
    @(posedge clk);
    clk_en <= 1'b0;
    meas(50, d0, d1);
    chk(d0, 32'h0);
    chk(d1, 32'h0);
    @(posedge clk);
    clk_en <= 1'b1;
    // counter1 stays on /8 while counter0 walks the taps
    for (int i = 0; i < 4; i++) begin
      wr_chk(SEL0_OFS, 32'(TAP_SEL[i]), RESP_OKAY);
      meas(2048, d0, d1);
      chk(d0, 32'h800 / TAP_DIV[i]);
      chk(d1, 32'h100);
    end
    wr_chk(SYNC_CTRL_OFS, 32'h1, RESP_OKAY);
    rd_chk(SYNC_CTRL_OFS, 32'h0, RESP_OKAY);
    meas(900, d0, d1);
    chk(d0, 32'h0);
    meas(200, d0, d1);
    chk(d0, 32'h1);
    wr_chk(SEL0_OFS, 32'(CS_DIV8), RESP_OKAY);
    wr_chk(SEL1_OFS, 32'(CS_EXT_RISE), RESP_OKAY);
    wr_chk(SYNC_CTRL_OFS, 32'h81, RESP_OKAY);
    rd_chk(SYNC_CTRL_OFS, 32'h81, RESP_OKAY);
    rd_chk(STATUS_OFS, 32'h0, RESP_OKAY);
    @(negedge clk);
    chk(32'(psr), 32'h1);
    ext_run(60, d0, d1, dr);
    chk(d0, 32'h0);
    chk(d1, dr);
    chk(32'(dr != 32'h0), 32'h1);
    wr_chk(SYNC_CTRL_OFS, 32'h0, RESP_OKAY);
    rd_chk(SYNC_CTRL_OFS, 32'h0, RESP_OKAY);
    @(negedge clk);
    chk(32'(psr), 32'h0);
    meas(80, d0, d1);
    chk(d0, 32'hA);
    wr_chk(SEL0_OFS, 32'(CS_EXT_FALL), RESP_OKAY);
    rd_chk(SEL0_OFS, 32'(CS_EXT_FALL), RESP_OKAY);
    ext_run(60, d0, d1, dr);
    chk(d0, dr);
    chk(d1, dr);
    close_out();
  end
endmodule
